// *** host_serial.sv ***
module host_serial (
    // Serial lines
    output logic sclk,
    output logic sel_n,
    output logic mosi,
    input wire logic miso,
    // Mode
    input wire logic cpol,
    input wire logic cpha
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] rd;
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        rd = 16'h0000;
    end
    ////////////////////////////////////////
    // Clock stands at idle level outside frames; nb of zero is a bare select pulse
    task automatic xfer(input logic [15:0] d, input int nb);
        // Idle level is set while deselected, so a mode change never looks like a sample edge
        sclk = cpol;
        #15 sel_n = 1'b0;
        #15;
        for (int k = 8 * nb - 1; k >= 0; k--) begin
            if (!cpha) mosi = d[k];
            #7.5;
            if (!cpha) rd = {rd[14:0], miso};
            sclk = ~cpol;
            #1 if (cpha) mosi = d[k];
            #6.5;
            if (cpha) rd = {rd[14:0], miso};
            sclk = cpol;
        end
        #15 sel_n = 1'b1;
        // Released data line shows the inverse so stale values never match
        mosi = ~mosi;
        #45;
    endtask : xfer
endmodule : host_serial

// *** pin_function_consts.svh ***
`ifndef PIN_FUNCTION_CONSTS_SVH
`define PIN_FUNCTION_CONSTS_SVH

// Timing, in ns with the core clock in MHz
`define SYS_CLK_MHZ 100
`define WAKE_TIME_NS 2000
`define WAKE_CYCLES ((`WAKE_TIME_NS * `SYS_CLK_MHZ + 999) / 1000)
`define LED_HOLD_NS 20000
`define LED_HOLD_CYCLES ((`LED_HOLD_NS * `SYS_CLK_MHZ) / 1000)
`define STRAP_CAPTURE_CYCLE 2'h2

// Pin positions
`define PIN_COUNT 9
`define PIN_IRQ 8
`define PIN_SYNC 7
`define PIN_PHASE 6
`define PIN_POLARITY 5
`define PIN_TRANSMIT_INDICATOR 3
`define PIN_RECEIVE_INDICATOR 2

// Power and timestamp figures
`define COARSE_STEP_HALF_DB 4
`define TS_WIDTH 40
`define DLY_WIDTH 16
`define EXT_ENABLE_RESET 1'b1

`endif

// *** pin_function_pkg.sv ***
`include "pin_function_consts.svh"

package pin_function_pkg;

    typedef enum logic [1:0] {PWR_WAKING, PWR_ACTIVE, PWR_SLEEP, PWR_DEEP} pwr_state_t;

    typedef enum logic [2:0] {PF_INPUT, PF_OUTPUT, PF_IRQ, PF_TRANSMIT_INDICATOR, PF_RECEIVE_INDICATOR, PF_SYNC} pin_fn_t;

    typedef struct packed {
        logic [`PIN_COUNT-1:0] dir_out;
        logic [`PIN_COUNT-1:0] out_val;
        logic [`PIN_COUNT-1:0] irq_en;
    } io_cfg_t;

    typedef struct packed {
        logic irq_as_io;
        logic irq_active_low;
        logic sync_as_io;
        logic transmit_indicator_en;
        logic receive_indicator_en;
    } pin_mode_t;

    typedef struct packed {
        logic [4:0] coarse;
        logic [1:0] fine;
        logic [7:0] bw_trim;
    } tx_power_t;

    typedef struct packed {
        logic valid;
        logic is_rx;
        logic [`TS_WIDTH-1:0] stamp;
    } stamp_req_t;

endpackage : pin_function_pkg

// *** pin_function_wake_strap.sv ***
//
// Contract
// [RL1] Falling chip select starts a new host serial transaction.
// [RL2] Chip select activity wakes the device from either low-power state.
// [RL3] High wake pin wakes the device; a grounded one never does.
// [RL4] External enable asserts during wake-up, drops on entering sleep.
// [RL5] Interrupt output is active high after reset; polarity is selectable.
// [RL6] Host keeps interrupt active high with pull-down; pin floats in sleep.
// [RL7] Interrupt pin can become general I/O line eight.
// [RL8] Pin seven defaults to timing-alignment input until reconfigured.
// [RL9] Pin six gives serial phase at power-up, then general I/O.
// [RL10] Pin five gives serial polarity at power-up, then general I/O.
// [RL11] Pin three can drive a transmit LED after each transmission.
// [RL12] Pin two can drive a receive LED during receive mode.
// [RL13] Transmit power in 2 dB coarse and 0.5 dB fine steps; bandwidth trim.
// [RL14] Programmable antenna delay, possibly from OTP, corrects timestamps.
// [RL15] All four serial polarity and phase modes are supported.
// [RL16] General pins reset to inputs; enabled inputs can raise interrupts.
// [RL17] Straps latch once at reset release and hold until next reset.
//
`include "pin_function_consts.svh"

module pin_function_wake_strap
    import pin_function_pkg::*;
#(
    parameter int WAKE_CYCLES = `WAKE_CYCLES,
    parameter int LED_HOLD_CYCLES = `LED_HOLD_CYCLES
) (
    // Core clock and reset
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // Host serial link
    input wire logic SERIAL_CLOCK_IN,
    input wire logic SERIAL_SELECT_LOW,
    input wire logic SERIAL_DATA_IN,
    output logic SERIAL_DATA_OUT,
    output logic SERIAL_DATA_OE_N,
    input wire logic [7:0] TX_BYTE,
    output logic TXN_START,
    output logic RX_BYTE_VALID,
    output logic [7:0] RX_BYTE,
    output logic SERIAL_POLARITY_STRAP,
    output logic SERIAL_PHASE_STRAP,
    // Wake and power
    input wire logic WAKE_REQUEST_PIN,
    input wire logic SLEEP_REQ,
    input wire logic DEEP_SLEEP_REQ,
    output logic EXTERNAL_ENABLE_OUT,
    output pwr_state_t POWER_STATE,
    // General pins
    input wire logic [`PIN_COUNT-1:0] GENERAL_IO_IN,
    output logic [`PIN_COUNT-1:0] GENERAL_IO_OUT,
    output logic [`PIN_COUNT-1:0] GENERAL_IO_OE_N,
    input wire io_cfg_t IO_CFG,
    input wire pin_mode_t PIN_MODE,
    input wire logic [`PIN_COUNT-1:0] IO_IRQ_CLR,
    output logic [`PIN_COUNT-1:0] IO_IRQ_PEND,
    output logic [`PIN_COUNT-1:0] IO_IN_VALUE,
    output logic SYNC_OUT,
    // Core events
    input wire logic CORE_IRQ,
    input wire logic TX_DONE,
    input wire logic RX_ACTIVE,
    // Transmit power
    input wire tx_power_t TX_POWER,
    output logic [6:0] TX_GAIN_HALF_DB,
    output logic [7:0] BW_TRIM_OUT,
    // Timestamp correction
    input wire stamp_req_t TS_REQ,
    input wire logic [`DLY_WIDTH-1:0] ANT_DLY_SW,
    input wire logic [`DLY_WIDTH-1:0] ANT_DLY_OTP,
    input wire logic DLY_FROM_OTP,
    output logic [`TS_WIDTH-1:0] TS_OUT,
    output logic TS_OUT_VALID
);

    localparam int SYNC_W = `PIN_COUNT + 2;
    localparam int WAKE_CNT_W = $clog2(WAKE_CYCLES + 1);
    localparam int LED_CNT_W = $clog2(LED_HOLD_CYCLES + 1);

    if (WAKE_CYCLES < 1 || LED_HOLD_CYCLES < 1) begin : g_check
        $error("wake and LED counts must be at least one");
    end

    function automatic pin_fn_t pin_fn(input int idx, input pin_mode_t m, input logic dir);
        pin_fn_t f;
        f = dir ? PF_OUTPUT : PF_INPUT;
        if (idx == `PIN_IRQ && !m.irq_as_io) f = PF_IRQ;
        else if (idx == `PIN_SYNC && !m.sync_as_io) f = PF_SYNC;
        else if (idx == `PIN_TRANSMIT_INDICATOR && m.transmit_indicator_en) f = PF_TRANSMIT_INDICATOR;
        else if (idx == `PIN_RECEIVE_INDICATOR && m.receive_indicator_en) f = PF_RECEIVE_INDICATOR;
        return f;
    endfunction : pin_fn

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic [SYNC_W-1:0] pin_sync;
    logic sel_low_s;
    logic wake_s;
    logic [`PIN_COUNT-1:0] io_s;

    sync2 #(
        .WIDTH(SYNC_W),
        .RESET_VAL({1'b1, 1'b0, {`PIN_COUNT{1'b0}}})
    ) u_pin_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .d({SERIAL_SELECT_LOW, WAKE_REQUEST_PIN, GENERAL_IO_IN}),
        .q(pin_sync)
    );

    assign sel_low_s = ~pin_sync[SYNC_W-1];
    assign wake_s = pin_sync[SYNC_W-2];
    assign io_s = pin_sync[`PIN_COUNT-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Serial link and byte crossing

    logic [7:0] link_byte;
    logic link_toggle;
    logic toggle_s;
    logic toggle_d_reg;
    logic sel_low_d_reg;

    // Straps are frozen long before the host may clock, so they feed the link directly
    serial_link u_link (
        .sclk(SERIAL_CLOCK_IN),
        .sel_n(SERIAL_SELECT_LOW),
        .rst_n(RST_N),
        .mosi(SERIAL_DATA_IN),
        .cpol(SERIAL_POLARITY_STRAP),
        .cpha(SERIAL_PHASE_STRAP),
        .tx_byte(TX_BYTE),
        .miso(SERIAL_DATA_OUT),
        .miso_oe_n(SERIAL_DATA_OE_N),
        .rx_byte(link_byte),
        .byte_toggle(link_toggle)
    );

    sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_toggle_sync (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .d(link_toggle),
        .q(toggle_s)
    );

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            toggle_d_reg <= 1'b0;
            sel_low_d_reg <= 1'b0;
            TXN_START <= 1'b0;
            RX_BYTE_VALID <= 1'b0;
            RX_BYTE <= 8'h00;
        end else begin
            toggle_d_reg <= toggle_s;
            sel_low_d_reg <= sel_low_s;
            TXN_START <= sel_low_s & ~sel_low_d_reg; // RL1
            RX_BYTE_VALID <= toggle_s ^ toggle_d_reg;
            if (toggle_s ^ toggle_d_reg) begin
                RX_BYTE <= link_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Power state and external enable

    pwr_state_t state_reg;
    pwr_state_t state_next;
    logic [WAKE_CNT_W-1:0] wake_cnt_reg;
    logic asleep;

    assign asleep = (state_reg == PWR_SLEEP) || (state_reg == PWR_DEEP);
    assign POWER_STATE = state_reg;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PWR_WAKING: begin
                if (wake_cnt_reg == WAKE_CNT_W'(WAKE_CYCLES - 1)) state_next = PWR_ACTIVE;
            end
            PWR_ACTIVE: begin
                if (DEEP_SLEEP_REQ) state_next = PWR_DEEP;
                else if (SLEEP_REQ) state_next = PWR_SLEEP;
            end
            PWR_SLEEP, PWR_DEEP: begin
                // A grounded wake pin with select idle keeps the device asleep
                if (wake_s || sel_low_s) state_next = PWR_WAKING; // RL2 RL3
            end
            default: state_next = PWR_WAKING;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= PWR_WAKING;
            wake_cnt_reg <= '0;
        end else begin
            state_reg <= state_next;
            wake_cnt_reg <= (state_reg == PWR_WAKING) ? wake_cnt_reg + WAKE_CNT_W'(1) : '0;
        end
    end

    // Enable follows the next state so it drops the same edge sleep is entered
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            EXTERNAL_ENABLE_OUT <= `EXT_ENABLE_RESET;
        end else begin
            EXTERNAL_ENABLE_OUT <= (state_next == PWR_WAKING) || (state_next == PWR_ACTIVE); // RL4
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strap capture

    logic [1:0] strap_cnt_reg;
    logic strap_done_reg;

    // Captured from the synchronised pins once they hold post-reset values
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_cnt_reg <= 2'h0;
            strap_done_reg <= 1'b0;
            SERIAL_POLARITY_STRAP <= 1'b0;
            SERIAL_PHASE_STRAP <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (strap_cnt_reg == `STRAP_CAPTURE_CYCLE) begin
                strap_done_reg <= 1'b1; // RL17
                SERIAL_POLARITY_STRAP <= io_s[`PIN_POLARITY]; // RL10
                SERIAL_PHASE_STRAP <= io_s[`PIN_PHASE]; // RL9
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin interrupts and indicators

    logic [`PIN_COUNT-1:0] io_s_d_reg;
    logic [`PIN_COUNT-1:0] io_rise;
    logic irq_level;
    logic [LED_CNT_W-1:0] led_cnt_reg;
    logic led_tx_on;

    assign io_rise = io_s & ~io_s_d_reg & IO_CFG.irq_en & ~IO_CFG.dir_out;
    assign irq_level = CORE_IRQ | (|IO_IRQ_PEND);
    assign led_tx_on = (led_cnt_reg != '0);

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            io_s_d_reg <= '0;
            IO_IRQ_PEND <= '0;
            IO_IN_VALUE <= '0;
            SYNC_OUT <= 1'b0;
        end else begin
            io_s_d_reg <= io_s;
            // A new edge in the clearing cycle survives the clear
            IO_IRQ_PEND <= (IO_IRQ_PEND & ~IO_IRQ_CLR) | io_rise; // RL16
            IO_IN_VALUE <= io_s;
            SYNC_OUT <= !PIN_MODE.sync_as_io && io_s[`PIN_SYNC]; // RL8
        end
    end

    // Retriggered by each transmission, so back-to-back frames keep it lit
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            led_cnt_reg <= '0;
        end else if (TX_DONE) begin
            led_cnt_reg <= LED_CNT_W'(LED_HOLD_CYCLES); // RL11
        end else if (led_tx_on) begin
            led_cnt_reg <= led_cnt_reg - LED_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers

    logic [`PIN_COUNT-1:0] io_out_next;
    logic [`PIN_COUNT-1:0] io_oe_n_next;

    for (genvar i = 0; i < `PIN_COUNT; i++) begin : g_pin
        logic out_b;
        logic oe_n_b;
        always_comb begin
            out_b = 1'b0;
            oe_n_b = 1'b1; // RL16
            case (pin_fn(i, PIN_MODE, IO_CFG.dir_out[i]))
                PF_OUTPUT: begin
                    out_b = IO_CFG.out_val[i]; // RL7
                    oe_n_b = 1'b0;
                end
                PF_IRQ: begin
                    // Floats in sleep; with active-high polarity the host's pull-down holds it inactive
                    out_b = irq_level ^ PIN_MODE.irq_active_low; // RL5
                    oe_n_b = (state_next == PWR_SLEEP) || (state_next == PWR_DEEP); // RL6
                end
                PF_TRANSMIT_INDICATOR: begin
                    out_b = led_tx_on; // RL11
                    oe_n_b = 1'b0;
                end
                PF_RECEIVE_INDICATOR: begin
                    out_b = RX_ACTIVE; // RL12
                    oe_n_b = 1'b0;
                end
                default: begin
                    out_b = 1'b0;
                    oe_n_b = 1'b1;
                end
            endcase
        end
        assign io_out_next[i] = out_b;
        assign io_oe_n_next[i] = oe_n_b;
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            GENERAL_IO_OUT <= '0;
            GENERAL_IO_OE_N <= '1;
        end else begin
            GENERAL_IO_OUT <= io_out_next;
            GENERAL_IO_OE_N <= io_oe_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit power and timestamp correction

    logic [`DLY_WIDTH-1:0] ant_dly;
    logic [`TS_WIDTH-1:0] dly_ext;

    assign ant_dly = DLY_FROM_OTP ? ANT_DLY_OTP : ANT_DLY_SW; // RL14
    assign dly_ext = {{(`TS_WIDTH - `DLY_WIDTH){1'b0}}, ant_dly};

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_GAIN_HALF_DB <= 7'h00;
            BW_TRIM_OUT <= 8'h00;
        end else begin
            TX_GAIN_HALF_DB <= 7'(TX_POWER.coarse * `COARSE_STEP_HALF_DB) + 7'(TX_POWER.fine); // RL13
            BW_TRIM_OUT <= TX_POWER.bw_trim; // RL13
        end
    end

    // Transmit stamps gain the delay, receive stamps lose it; the timer wraps
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            TS_OUT <= '0;
            TS_OUT_VALID <= 1'b0;
        end else begin
            TS_OUT_VALID <= TS_REQ.valid;
            if (TS_REQ.valid) begin
                TS_OUT <= TS_REQ.is_rx ? TS_REQ.stamp - dly_ext : TS_REQ.stamp + dly_ext; // RL14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_start_on_fall: assert property (sel_low_s && !sel_low_d_reg |=> TXN_START) // RL1
        else $error("select fall did not start a transaction");
    a_wake_on_select: assert property (asleep && sel_low_s |=> state_reg == PWR_WAKING) // RL2
        else $error("select activity did not wake the device");
    a_wake_on_pin: assert property (asleep && wake_s |=> EXTERNAL_ENABLE_OUT) // RL3
        else $error("wake pin did not raise external enable");
    a_no_false_wake: assert property (asleep && !wake_s && !sel_low_s |=> asleep) // RL3
        else $error("device woke without a wake source");
    a_enable_in_sleep: assert property (asleep |-> !EXTERNAL_ENABLE_OUT) // RL4
        else $error("external enable held during sleep");
    a_irq_polarity: assert property (!asleep && !PIN_MODE.irq_as_io && !PIN_MODE.irq_active_low
        |=> GENERAL_IO_OUT[`PIN_IRQ] == $past(irq_level)) // RL5
        else $error("interrupt pin not active high");
    a_irq_as_io: assert property (PIN_MODE.irq_as_io && IO_CFG.dir_out[`PIN_IRQ]
        |=> !GENERAL_IO_OE_N[`PIN_IRQ] && GENERAL_IO_OUT[`PIN_IRQ] == $past(IO_CFG.out_val[`PIN_IRQ])) // RL7
        else $error("interrupt pin not serving as general output");
    a_sync_default: assert property (!PIN_MODE.sync_as_io |=> GENERAL_IO_OE_N[`PIN_SYNC]) // RL8
        else $error("alignment pin driven while an input");
    a_strap_hold: assert property (strap_done_reg |=>
        $stable(SERIAL_POLARITY_STRAP) && $stable(SERIAL_PHASE_STRAP)) // RL17
        else $error("strap value changed after capture");
    a_tx_led: assert property (PIN_MODE.transmit_indicator_en && TX_DONE ##1 PIN_MODE.transmit_indicator_en
        |=> GENERAL_IO_OUT[`PIN_TRANSMIT_INDICATOR]) // RL11
        else $error("transmit LED not lit after transmission");
    a_rx_led: assert property (PIN_MODE.receive_indicator_en && RX_ACTIVE |=> GENERAL_IO_OUT[`PIN_RECEIVE_INDICATOR]) // RL12
        else $error("receive LED not following receive mode");
    a_pend_set_wins: assert property (|io_rise |=> |IO_IRQ_PEND) // RL16
        else $error("input edge lost from pending flags");
    a_stamp_tx: assert property (TS_REQ.valid && !TS_REQ.is_rx
        |=> TS_OUT == $past(TS_REQ.stamp) + $past(dly_ext)) // RL14
        else $error("transmit stamp not delay corrected");

    c_sleep_pin_wake: cover property (asleep && wake_s && !sel_low_s ##1 state_reg == PWR_WAKING);
    c_sleep_sel_wake: cover property (asleep && sel_low_s ##1 state_reg == PWR_WAKING);
    c_byte_received: cover property (TXN_START ##[1:200] RX_BYTE_VALID);
    c_deep_sleep: cover property (state_reg == PWR_ACTIVE ##1 state_reg == PWR_DEEP);

endmodule : pin_function_wake_strap

// *** serial_link.sv ***
module serial_link (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic rst_n,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic [7:0] tx_byte,
    output logic miso,
    output logic miso_oe_n,
    output logic [7:0] rx_byte,
    output logic byte_toggle
);

    logic sample_clk;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;

    // Sample edge: leading edge for phase 0, trailing for phase 1
    assign sample_clk = sclk ^ cpol ^ cpha;

    // Select high clears the frame, so a stopped clock leaves nothing pending
    always_ff @(posedge sample_clk or posedge sel_n) begin
        if (sel_n) begin
            bit_cnt_reg <= 3'h0; // RL1
            shift_reg <= 7'h00;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            shift_reg <= {shift_reg[5:0], mosi}; // RL15
        end
    end

    // Byte stays put for eight sample edges, long enough for the toggle to cross
    always_ff @(posedge sample_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_byte <= 8'h00;
            byte_toggle <= 1'b0;
        end else if (!sel_n && bit_cnt_reg == 3'h7) begin
            rx_byte <= {shift_reg, mosi};
            byte_toggle <= ~byte_toggle;
        end
    end

    // Next bit is on the line right after each sample edge, MSB first
    assign miso = tx_byte[~bit_cnt_reg]; // RL15
    assign miso_oe_n = sel_n;

endmodule : serial_link

// *** sync2.sv ***
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_reg;

    if (WIDTH < 1) begin : g_check
        $error("sync2 width must be at least one");
    end

    // The first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule : sync2

// *** tb.sv ***
module tb;
    import pin_function_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    // Short counts keep the run brief
    localparam int WK = 4;
    localparam int LH = 8;
    logic SYS_CLK = 1'b0;
    logic RST_N;
    logic sclk, sel_n, mosi, miso, miso_oe_n, txn_start, rx_valid, pol_s, pha_s, ext_en, sync_out, ts_valid;
    logic wake, slp, dslp, core_irq, tx_done, rx_act, dly_sel, b;
    logic [1:0] hm;
    logic [7:0] tx_byte, rx_byte, bw;
    logic [6:0] gain;
    logic [8:0] pin_drv, gio_out, gio_oe_n, irq_clr, irq_pend, io_val;
    logic [15:0] dly_sw, dly_otp, dly, d;
    logic [39:0] ts_out, e;
    logic [39:0] expq[$];
    pwr_state_t pwr;
    io_cfg_t cfg;
    pin_mode_t mode;
    tx_power_t pwr_in;
    stamp_req_t ts_req;
    int fails = 0;
    int checks = 0;
    int starts = 0;
    int cyc = 0;
    // Undriven interrupt pin sits on its pull-down
    wire logic [8:0] gio_in = (gio_oe_n & pin_drv) | (~gio_oe_n & gio_out);
    always #5 SYS_CLK = ~SYS_CLK;

    pin_function_wake_strap #(.WAKE_CYCLES(WK), .LED_HOLD_CYCLES(LH)) u_pin_function_wake_strap (
        .SYS_CLK(SYS_CLK), .RST_N(RST_N), .SERIAL_CLOCK_IN(sclk), .SERIAL_SELECT_LOW(sel_n),
        .SERIAL_DATA_IN(mosi), .SERIAL_DATA_OUT(miso), .SERIAL_DATA_OE_N(miso_oe_n), .TX_BYTE(tx_byte),
        .TXN_START(txn_start), .RX_BYTE_VALID(rx_valid), .RX_BYTE(rx_byte), .SERIAL_POLARITY_STRAP(pol_s),
        .SERIAL_PHASE_STRAP(pha_s), .WAKE_REQUEST_PIN(wake), .SLEEP_REQ(slp), .DEEP_SLEEP_REQ(dslp),
        .EXTERNAL_ENABLE_OUT(ext_en), .POWER_STATE(pwr), .GENERAL_IO_IN(gio_in), .GENERAL_IO_OUT(gio_out),
        .GENERAL_IO_OE_N(gio_oe_n), .IO_CFG(cfg), .PIN_MODE(mode), .IO_IRQ_CLR(irq_clr), .IO_IRQ_PEND(irq_pend),
        .IO_IN_VALUE(io_val), .SYNC_OUT(sync_out), .CORE_IRQ(core_irq), .TX_DONE(tx_done), .RX_ACTIVE(rx_act),
        .TX_POWER(pwr_in), .TX_GAIN_HALF_DB(gain), .BW_TRIM_OUT(bw), .TS_REQ(ts_req), .ANT_DLY_SW(dly_sw),
        .ANT_DLY_OTP(dly_otp), .DLY_FROM_OTP(dly_sel), .TS_OUT(ts_out), .TS_OUT_VALID(ts_valid)
    );
    host_serial u_host_serial (.sclk(sclk), .sel_n(sel_n), .mosi(mosi), .miso(miso), .cpol(hm[0]), .cpha(hm[1]));

    ////////////////////////////////////////
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    task automatic step(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : step
    task automatic do_reset(input logic [1:0] m);
        RST_N = 1'b0;
        pin_drv = {2'b00, m, 5'h00};
        step(4);
        RST_N = 1'b1;
        chk(ext_en, 1'b1);
        chk(pwr, PWR_WAKING);
        step(5);
        // Moving the strap pins later must not disturb the latched mode
        pin_drv[6:5] = ~m;
        step(WK + 4);
        chk(pol_s, m[0]);
        chk(pha_s, m[1]);
        chk(gio_oe_n[7:0], 8'hFF);
        chk(pwr, PWR_ACTIVE);
    endtask : do_reset

    // Results are compared against notes in arrival order
    always @(posedge SYS_CLK) begin
        if (txn_start === 1'b1) starts++;
        if (rx_valid === 1'b1 || ts_valid === 1'b1) begin
            if (expq.size() == 0) expq.push_back('X);
            chk(rx_valid ? {32'h0000_0000, rx_byte} : ts_out, expq.pop_front());
        end
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end

    ////////////////////////////////////////
    initial begin
        {wake, slp, dslp, core_irq, tx_done, rx_act, dly_sel} = 7'h00;
        {tx_byte, irq_clr, dly_sw, dly_otp, hm} = '0;
        cfg = '0;
        mode = '0;
        pwr_in = '0;
        ts_req = '0;
        void'($urandom(32'hFCC03A68));
        for (int m = 0; m < 4; m++) begin
            do_reset(2'(m));
            hm = 2'(m);
            tx_byte = 8'($urandom);
            d = 16'($urandom);
            expq.push_back({32'h0000_0000, d[15:8]});
            expq.push_back({32'h0000_0000, d[7:0]});
            u_host_serial.xfer(d, 2);
            step(8);
            chk(u_host_serial.rd, {tx_byte, tx_byte});
            chk(miso_oe_n, 1'b1);
        end
        chk(starts, 4);
        dslp = 1'b1;
        step(1);
        dslp = 1'b0;
        chk({pwr, ext_en, gio_oe_n[8]}, {PWR_DEEP, 2'b01});
        step(10);
        chk(pwr, PWR_DEEP);
        wake = 1'b1;
        step(4);
        wake = 1'b0;
        chk({pwr, ext_en}, {PWR_WAKING, 1'b1});
        step(WK + 2);
        slp = 1'b1;
        step(1);
        slp = 1'b0;
        chk(pwr, PWR_SLEEP);
        u_host_serial.xfer(16'h0000, 0);
        step(4);
        chk({pwr === PWR_SLEEP, ext_en}, 2'b01);
        core_irq = 1'b1;
        step(2);
        chk({gio_out[8], gio_oe_n[8]}, 2'b10);
        mode.irq_active_low = 1'b1;
        step(2);
        chk(gio_out[8], 1'b0);
        b = 1'($urandom);
        mode.irq_as_io = 1'b1;
        cfg.dir_out[8] = 1'b1;
        cfg.out_val[8] = b;
        cfg.irq_en[4] = 1'b1;
        pin_drv[4] = 1'b1;
        pin_drv[7] = 1'b1;
        step(5);
        chk(gio_out[8], b);
        chk({irq_pend[4], io_val[4]}, 2'b11);
        chk({sync_out, gio_oe_n[7]}, 2'b11);
        irq_clr[4] = 1'b1;
        mode.sync_as_io = 1'b1;
        cfg.dir_out[7] = 1'b1;
        step(1);
        irq_clr[4] = 1'b0;
        step(1);
        chk(irq_pend[4], 1'b0);
        chk(gio_oe_n[7], 1'b0);
        mode.transmit_indicator_en = 1'b1;
        mode.receive_indicator_en = 1'b1;
        rx_act = 1'b1;
        tx_done = 1'b1;
        step(1);
        tx_done = 1'b0;
        step(3);
        chk(gio_out[3:2], 2'b11);
        rx_act = 1'b0;
        step(LH + 4);
        chk(gio_out[3:2], 2'b00);
        for (int i = 0; i < 6; i++) begin
            pwr_in = 15'($urandom);
            ts_req = 42'({$urandom, $urandom});
            ts_req.valid = 1'b1;
            dly_sw = 16'($urandom);
            dly_otp = 16'($urandom);
            dly_sel = 1'($urandom);
            dly = dly_sel ? dly_otp : dly_sw;
            e = ts_req.is_rx ? ts_req.stamp - {24'h000000, dly} : ts_req.stamp + {24'h000000, dly};
            expq.push_back(e);
            step(1);
            ts_req.valid = 1'b0;
            step(1);
            chk({gain, bw}, {7'(pwr_in.coarse * 4 + pwr_in.fine), pwr_in.bw_trim});
        end
        step(3);
        chk(expq.size(), 0);
        give_verdict();
    end
endmodule : tb
